//--- logic/srq_pkg.sv
// Constants for the split ring queue driver-side controller.
// Operation
// - Queue size is a 16-bit value setting ring and table entry counts.
// - Queue size is a power of two, at most 32768, bounding buffers outstanding.
// - Alignment: descriptor table 16, available ring 2, used ring 4 bytes.
// - Sizes: 16 per descriptor; 6+2 per avail entry; 6+8 per used entry.
// - Driver places each part's base on a multiple of its alignment.
// - Descriptor: 64-bit address, 32-bit length, 16-bit flags, 16-bit next.
// - Flag 1 continues the chain, flag 4 marks indirect; another marks writable.
// - Each buffer is device-readable or device-writable; chains may mix both.
// - Driver puts all writable descriptors after all readable ones in a chain.
// - Chain total below 2^32 bytes and no longer than queue size.
// - In order, descriptors used sequentially from 0; next wraps to 0.
// - Indirect descriptor gives table address and byte size; entries = len/16.
// - In order, indirect entry k carries next equal to k plus one.
// - Indirect flag only if negotiated, never nested, never with continue.
// - Avail entries name chain heads; index starts 0, free-running, driver-written.
// - Driver never decrements the available index.
// - Queue fields are little-endian outside legacy operation.
package srq_pkg;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_QSIZE = 8'h04;
    localparam logic [7:0] REG_DESC_LO = 8'h08;
    localparam logic [7:0] REG_DESC_HI = 8'h0C;
    localparam logic [7:0] REG_AVAIL_LO = 8'h10;
    localparam logic [7:0] REG_AVAIL_HI = 8'h14;
    localparam logic [7:0] REG_USED_LO = 8'h18;
    localparam logic [7:0] REG_USED_HI = 8'h1C;
    localparam logic [7:0] REG_BUF_LO = 8'h20;
    localparam logic [7:0] REG_BUF_HI = 8'h24;
    localparam logic [7:0] REG_BUF_LEN = 8'h28;
    localparam logic [7:0] REG_PUSH = 8'h2C;
    localparam logic [7:0] REG_IND_LO = 8'h30;
    localparam logic [7:0] REG_IND_HI = 8'h34;
    localparam logic [7:0] REG_STATUS = 8'h38;
    localparam logic [7:0] REG_DONE = 8'h3C;
    localparam logic [7:0] REG_DONE_LEN = 8'h40;
    localparam logic [7:0] REG_FREE = 8'h44;
    // CTRL bits
    localparam int CTRL_READY = 0;
    localparam int CTRL_IND_EN = 1;
    localparam int CTRL_POLL = 2;
    localparam int CTRL_CLR_ERR = 3;
    // PUSH bits
    localparam int PUSH_WRITABLE = 0;
    localparam int PUSH_LAST = 1;
    localparam int PUSH_INDIRECT = 2;
    // Descriptor flags
    localparam logic [15:0] DESC_F_NEXT = 16'h0001;
    localparam logic [15:0] DESC_F_WRITE = 16'h0002;
    localparam logic [15:0] DESC_F_INDIRECT = 16'h0004;
    // Layout
    localparam logic [16:0] QSIZE_MAX = 17'h08000;
    localparam logic [63:0] DESC_ALIGN_MASK = 64'h000000000000000F;
    localparam logic [63:0] AVAIL_ALIGN_MASK = 64'h0000000000000001;
    localparam logic [63:0] USED_ALIGN_MASK = 64'h0000000000000003;
    localparam logic [63:0] AVAIL_IDX_OFS = 64'h0000000000000002;
    localparam logic [63:0] AVAIL_RING_OFS = 64'h0000000000000004;
    localparam logic [63:0] USED_RING_OFS = 64'h0000000000000004;
    localparam logic [63:0] USED_LEN_OFS = 64'h0000000000000004;
    localparam int DESC_SHIFT = 4;
    localparam int AVAIL_SHIFT = 1;
    localparam int USED_SHIFT = 3;
    localparam int MAX_CHAINS = 16;
    localparam int CHAIN_IW = 4;
endpackage : srq_pkg

//--- logic/srq_sync.sv
// Two-flop synchroniser for a level arriving from outside the clock domain.
`timescale 1ns/1ps
module srq_sync (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic d,
    output logic q
);
    logic meta;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta <= 1'b0;
            q <= 1'b0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule : srq_sync

//--- logic/srq_chain_check.sv
// Checks that one more descriptor may legally join the chain being built.
`timescale 1ns/1ps
module srq_chain_check (
    input wire logic first,
    input wire logic writable,
    input wire logic saw_writable,
    input wire logic [31:0] len,
    input wire logic [32:0] total_len,
    input wire logic [15:0] chain_cnt,
    input wire logic [15:0] qsize,
    output logic order_err,
    output logic len_err,
    output logic cnt_err
);
    logic [32:0] sum;

    always_comb begin
        sum = (first ? 33'h000000000 : total_len) + {1'b0, len};
        order_err = !first && saw_writable && !writable;
        len_err = sum[32];
        cnt_err = !first && (chain_cnt >= qsize);
    end
endmodule : srq_chain_check

//--- logic/srq_driver.sv
// Driver-side controller: builds descriptor chains, publishes them, reaps used entries.
`timescale 1ns/1ps
module srq_driver
    import srq_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic mem_req,
    output logic mem_we,
    output logic [63:0] mem_addr,
    output logic [31:0] mem_wdata,
    output logic [3:0] mem_be,
    input wire logic mem_ack,
    input wire logic [31:0] mem_rdata,
    output logic driver_ready,
    output logic notify,
    input wire logic dev_irq
);
    typedef enum {ST_IDLE, ST_DESC, ST_AV_ENT, ST_AV_IDX, ST_NOTIFY,
                  ST_RD_IDX, ST_RD_ID, ST_RD_LEN} srq_state_e;
    srq_state_e state;

    logic ctrl_ready, ind_en;
    logic [15:0] qsize;
    logic [63:0] desc_base, avail_base, used_base, ind_base, buf_addr;
    logic [31:0] buf_len;
    logic [15:0] chain_cnt, head, next_slot, ind_k;
    logic saw_wr, chain_ind, cur_last, cur_main;
    logic [32:0] total_len;
    logic [63:0] cur_tgt, cur_addr;
    logic [31:0] cur_len;
    logic [15:0] cur_flags, cur_next;
    logic [1:0] wcnt;
    logic [15:0] avail_idx, last_used, dev_used_idx, done_id;
    logic [31:0] done_len;
    logic [16:0] free_cnt;
    logic [15:0] slots_mem [MAX_CHAINS];
    logic err_order, err_len, err_cfg, err_ind, err_busy;
    logic poll_pend, irq_s, irq_d;

    logic [15:0] qmask, slot_nx, chain_slots;
    logic cfg_ok, first, push, p_wr, p_last, p_ind, mode_ind;
    logic chk_order, chk_len, chk_cnt, room, accept;
    logic [63:0] av_addr, used_elem, idx_addr;
    logic [15:0] in_flight;

    srq_sync u_irq_sync (
        .clk(clk),
        .reset_n(reset_n),
        .d(dev_irq),
        .q(irq_s)
    );

    srq_chain_check u_check (
        .first(first),
        .writable(p_wr),
        .saw_writable(saw_wr),
        .len(buf_len),
        .total_len(total_len),
        .chain_cnt(chain_cnt),
        .qsize(qsize),
        .order_err(chk_order),
        .len_err(chk_len),
        .cnt_err(chk_cnt)
    );

    always_comb begin
        qmask = qsize - 16'h0001;
        slot_nx = (next_slot + 16'h0001) & qmask;
        cfg_ok = (qsize != 16'h0000) && ((qsize & qmask) == 16'h0000)
            && ({1'b0, qsize} <= QSIZE_MAX)
            && ((desc_base & DESC_ALIGN_MASK) == 64'h0)
            && ((avail_base & AVAIL_ALIGN_MASK) == 64'h0)
            && ((used_base & USED_ALIGN_MASK) == 64'h0)
            && ((ind_base & DESC_ALIGN_MASK) == 64'h0);
        first = (chain_cnt == 16'h0000);
        push = reg_wr && (reg_addr == REG_PUSH);
        p_wr = reg_wdata[PUSH_WRITABLE];
        p_last = reg_wdata[PUSH_LAST];
        p_ind = reg_wdata[PUSH_INDIRECT];
        mode_ind = first ? p_ind : chain_ind;
        in_flight = avail_idx - last_used;
        // Free slots: direct chains take one per descriptor, indirect takes the one main slot
        room = (free_cnt != 17'h00000) && (in_flight < 16'(MAX_CHAINS));
        accept = push && (state == ST_IDLE) && ctrl_ready && cfg_ok && room
            && !chk_order && !chk_len && !chk_cnt
            && !(mode_ind && !ind_en);
        chain_slots = chain_ind ? 16'h0001 : chain_cnt;
        av_addr = avail_base + AVAIL_RING_OFS + 64'({avail_idx & qmask, 1'b0});
        used_elem = used_base + USED_RING_OFS + 64'({last_used & qmask, 3'b000});
        // A ring base on a 2-byte boundary puts the index in the following word
        idx_addr = avail_base + AVAIL_IDX_OFS;
    end

    // Memory request mux; addresses are word aligned, 16-bit fields go on lanes
    always_comb begin
        mem_req = 1'b0;
        mem_we = 1'b0;
        mem_addr = 64'h0;
        mem_wdata = 32'h0;
        mem_be = 4'hF;
        case (state)
            ST_DESC: begin
                mem_req = 1'b1;
                mem_we = 1'b1;
                mem_addr = cur_tgt + 64'({wcnt, 2'b00});
                case (wcnt)
                    2'd0: mem_wdata = cur_addr[31:0];
                    2'd1: mem_wdata = cur_addr[63:32];
                    2'd2: mem_wdata = cur_len;
                    default: mem_wdata = {cur_next, cur_flags};
                endcase
            end
            ST_AV_ENT: begin
                mem_req = 1'b1;
                mem_we = 1'b1;
                mem_addr = {av_addr[63:2], 2'b00};
                mem_wdata = {head, head};
                mem_be = av_addr[1] ? 4'hC : 4'h3;
            end
            ST_AV_IDX: begin
                mem_req = 1'b1;
                mem_we = 1'b1;
                mem_addr = {idx_addr[63:2], 2'b00};
                mem_wdata = {avail_idx + 16'h0001, avail_idx + 16'h0001};
                mem_be = idx_addr[1] ? 4'hC : 4'h3;
            end
            ST_RD_IDX: begin
                mem_req = 1'b1;
                mem_addr = used_base;
            end
            ST_RD_ID: begin
                mem_req = 1'b1;
                mem_addr = used_elem;
            end
            ST_RD_LEN: begin
                mem_req = 1'b1;
                mem_addr = used_elem + USED_LEN_OFS;
            end
            default: ;
        endcase
    end

    // Software configuration
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_ready <= 1'b0;
            ind_en <= 1'b0;
            qsize <= 16'h0000;
            desc_base <= 64'h0;
            avail_base <= 64'h0;
            used_base <= 64'h0;
            ind_base <= 64'h0;
            buf_addr <= 64'h0;
            buf_len <= 32'h0;
        end else if (reg_wr) begin
            case (reg_addr)
                REG_CTRL: begin
                    ctrl_ready <= reg_wdata[CTRL_READY];
                    ind_en <= reg_wdata[CTRL_IND_EN];
                end
                REG_QSIZE: qsize <= reg_wdata[15:0];
                REG_DESC_LO: desc_base[31:0] <= reg_wdata;
                REG_DESC_HI: desc_base[63:32] <= reg_wdata;
                REG_AVAIL_LO: avail_base[31:0] <= reg_wdata;
                REG_AVAIL_HI: avail_base[63:32] <= reg_wdata;
                REG_USED_LO: used_base[31:0] <= reg_wdata;
                REG_USED_HI: used_base[63:32] <= reg_wdata;
                REG_IND_LO: ind_base[31:0] <= reg_wdata;
                REG_IND_HI: ind_base[63:32] <= reg_wdata;
                REG_BUF_LO: buf_addr[31:0] <= reg_wdata;
                REG_BUF_HI: buf_addr[63:32] <= reg_wdata;
                REG_BUF_LEN: buf_len <= reg_wdata;
                default: ;
            endcase
        end
    end

    // Device may only run once the queue is configured and marked ready
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            driver_ready <= 1'b0;
        end else begin
            driver_ready <= ctrl_ready && cfg_ok;
        end
    end

    // Error flags: a new error in the clearing cycle survives
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            err_order <= 1'b0;
            err_len <= 1'b0;
            err_cfg <= 1'b0;
            err_ind <= 1'b0;
            err_busy <= 1'b0;
        end else begin
            if (reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_CLR_ERR]) begin
                err_order <= 1'b0;
                err_len <= 1'b0;
                err_cfg <= 1'b0;
                err_ind <= 1'b0;
                err_busy <= 1'b0;
            end
            if (push && !accept) begin
                if (chk_order) err_order <= 1'b1;
                if (chk_len || chk_cnt) err_len <= 1'b1;
                if (!cfg_ok || !ctrl_ready) err_cfg <= 1'b1;
                if (mode_ind && !ind_en) err_ind <= 1'b1;
                if (state != ST_IDLE || !room) err_busy <= 1'b1;
            end
        end
    end

    // Poll request from the device interrupt edge or from software
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_d <= 1'b0;
            poll_pend <= 1'b0;
        end else begin
            irq_d <= irq_s;
            if (state == ST_IDLE && !push && poll_pend) poll_pend <= 1'b0;
            if ((irq_s && !irq_d) || (reg_wr && reg_addr == REG_CTRL
                && reg_wdata[CTRL_POLL])) poll_pend <= 1'b1;
        end
    end

    // Chain building, publishing and reaping
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= ST_IDLE;
            chain_cnt <= 16'h0000;
            head <= 16'h0000;
            next_slot <= 16'h0000;
            ind_k <= 16'h0000;
            saw_wr <= 1'b0;
            chain_ind <= 1'b0;
            total_len <= 33'h0;
            cur_last <= 1'b0;
            cur_main <= 1'b0;
            cur_tgt <= 64'h0;
            cur_addr <= 64'h0;
            cur_len <= 32'h0;
            cur_flags <= 16'h0000;
            cur_next <= 16'h0000;
            wcnt <= 2'd0;
            avail_idx <= 16'h0000;
            last_used <= 16'h0000;
            dev_used_idx <= 16'h0000;
            done_id <= 16'h0000;
            done_len <= 32'h0;
            free_cnt <= 17'h0;
            notify <= 1'b0;
        end else begin
            notify <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (!ctrl_ready) begin
                        // Queue restarts from empty whenever ready is dropped
                        chain_cnt <= 16'h0000;
                        next_slot <= 16'h0000;
                        avail_idx <= 16'h0000;
                        last_used <= 16'h0000;
                        free_cnt <= {1'b0, qsize};
                    end else if (accept) begin
                        wcnt <= 2'd0;
                        cur_last <= p_last;
                        cur_main <= 1'b0;
                        cur_addr <= buf_addr;
                        cur_len <= buf_len;
                        chain_cnt <= chain_cnt + 16'h0001;
                        saw_wr <= p_wr || (!first && saw_wr);
                        total_len <= (first ? 33'h0 : total_len) + {1'b0, buf_len};
                        chain_ind <= mode_ind;
                        cur_flags <= (p_wr ? DESC_F_WRITE : 16'h0000)
                            | (p_last ? 16'h0000 : DESC_F_NEXT);
                        if (mode_ind) begin
                            ind_k <= first ? 16'h0001 : ind_k + 16'h0001;
                            cur_tgt <= ind_base + 64'({first ? 16'h0000 : ind_k, 4'h0});
                            cur_next <= p_last ? 16'h0000
                                : (first ? 16'h0001 : ind_k + 16'h0001);
                        end else begin
                            if (first) head <= next_slot;
                            cur_tgt <= desc_base + 64'({next_slot, 4'h0});
                            cur_next <= p_last ? 16'h0000 : slot_nx;
                            next_slot <= slot_nx;
                            free_cnt <= free_cnt - 17'h00001;
                        end
                        state <= ST_DESC;
                    end else if (poll_pend && !push) begin
                        state <= ST_RD_IDX;
                    end
                end
                ST_DESC: if (mem_ack) begin
                    wcnt <= wcnt + 2'd1;
                    if (wcnt == 2'd3) begin
                        if (!cur_last) begin
                            state <= ST_IDLE;
                        end else if (chain_ind && !cur_main) begin
                            // One main slot refers to the whole table
                            cur_main <= 1'b1;
                            head <= next_slot;
                            cur_tgt <= desc_base + 64'({next_slot, 4'h0});
                            cur_addr <= ind_base;
                            cur_len <= {12'h000, ind_k, 4'h0};
                            cur_flags <= DESC_F_INDIRECT;
                            cur_next <= 16'h0000;
                            next_slot <= slot_nx;
                            free_cnt <= free_cnt - 17'h00001;
                        end else begin
                            state <= ST_AV_ENT;
                        end
                    end
                end
                ST_AV_ENT: if (mem_ack) state <= ST_AV_IDX;
                ST_AV_IDX: if (mem_ack) begin
                    avail_idx <= avail_idx + 16'h0001;
                    chain_cnt <= 16'h0000;
                    state <= ST_NOTIFY;
                end
                ST_NOTIFY: begin
                    notify <= ctrl_ready && cfg_ok;
                    state <= ST_IDLE;
                end
                ST_RD_IDX: if (mem_ack) begin
                    dev_used_idx <= mem_rdata[31:16];
                    state <= (mem_rdata[31:16] != last_used) ? ST_RD_ID : ST_IDLE;
                end
                ST_RD_ID: if (mem_ack) begin
                    done_id <= mem_rdata[15:0];
                    state <= ST_RD_LEN;
                end
                ST_RD_LEN: if (mem_ack) begin
                    done_len <= mem_rdata;
                    // Reclaim assumes completions return in publish order
                    free_cnt <= free_cnt + {1'b0, slots_mem[last_used[CHAIN_IW-1:0]]};
                    last_used <= last_used + 16'h0001;
                    state <= ST_RD_IDX;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Slots used by each chain in flight, indexed by its avail index
    always_ff @(posedge clk) begin
        if (state == ST_AV_IDX && mem_ack) begin
            slots_mem[avail_idx[CHAIN_IW-1:0]] <= chain_slots;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 32'h0;
        end else if (reg_rd) begin
            case (reg_addr)
                REG_CTRL: reg_rdata <= {30'h0, ind_en, ctrl_ready};
                REG_QSIZE: reg_rdata <= {16'h0000, qsize};
                REG_STATUS: reg_rdata <= {avail_idx, 9'h000, err_busy, err_ind, err_cfg,
                    err_len, err_order, cfg_ok, state != ST_IDLE};
                REG_DONE: reg_rdata <= {done_id, last_used};
                REG_DONE_LEN: reg_rdata <= done_len;
                REG_FREE: reg_rdata <= {dev_used_idx, chain_cnt[14:0], free_cnt == 17'h0};
                default: reg_rdata <= 32'h0;
            endcase
        end
    end
endmodule : srq_driver

//--- tb/srq_driver_asserts.sv
// Port-level property checks for the queue controller.
`timescale 1ns/1ps
module srq_driver_asserts (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic reg_wr,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [63:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    input wire logic [3:0] mem_be,
    input wire logic mem_ack,
    input wire logic driver_ready,
    input wire logic notify
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    AST_REQ_HOLD: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
        else $error("memory request moved before ack");
    AST_WORD_ALIGN: assert property (mem_req |-> mem_addr[1:0] == 2'b00)
        else $error("memory address not word aligned");
    AST_LANES: assert property (mem_req && mem_we |-> mem_be inside {4'hF, 4'h3, 4'hC})
        else $error("illegal byte lanes on write");
    AST_HALF_DUP: assert property (mem_req && mem_we && mem_be != 4'hF |->
        mem_wdata[31:16] == mem_wdata[15:0]) else $error("half-word write not duplicated");
    AST_NOTIFY_PULSE: assert property (notify |=> !notify)
        else $error("notify longer than one cycle");
    AST_NOTIFY_READY: assert property (notify |-> driver_ready)
        else $error("notify while not ready");
    AST_RESET_QUIET: assert property ($rose(reset_n) |-> !mem_req && !notify && !driver_ready)
        else $error("outputs active at reset release");
    AST_READY_CAUSE: assert property ($rose(driver_ready) |-> $past(reg_wr) || $past(reg_wr, 2))
        else $error("ready rose without a register write");
endmodule : srq_driver_asserts
bind srq_driver srq_driver_asserts u_chk (.clk, .reset_n, .reg_wr, .mem_req, .mem_we,
    .mem_addr, .mem_wdata, .mem_be, .mem_ack, .driver_ready, .notify);

//--- tb/srq_dev_model.sv
// Shared memory and device model facing the queue controller.
`timescale 1ns/1ps
module srq_dev_model #(
    parameter logic [63:0] DT = 64'h100,
    parameter logic [63:0] AV = 64'h200,
    parameter logic [63:0] US = 64'h300
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [63:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    input wire logic [3:0] mem_be,
    output logic mem_ack,
    output logic [31:0] mem_rdata,
    input wire logic notify,
    input wire logic driver_ready,
    input wire logic [3:0] dly,
    output logic dev_irq = 1'b0
);
    logic [31:0] mem [logic [63:0]];
    logic [31:0] w, f, ln;
    logic [15:0] seen = 16'h0, uidx = 16'h0, hd;
    logic [3:0] cnt;
    function automatic logic [31:0] rw(input logic [63:0] a);
        return mem.exists(a) ? mem[a] : 32'h0;
    endfunction : rw
    // Released read data toggles so a stale word is never mistaken for an answer
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mem_ack <= 1'b0;
            cnt <= 4'h0;
            mem_rdata <= 32'h0;
        end else if (mem_req && !mem_ack && cnt >= dly) begin
            mem_ack <= 1'b1;
            cnt <= 4'h0;
            mem_rdata <= rw(mem_addr);
            w = rw(mem_addr);
            for (int b = 0; b < 4; b++) if (mem_be[b]) w[8*b+:8] = mem_wdata[8*b+:8];
            if (mem_we) mem[mem_addr] = w;
        end else begin
            mem_ack <= 1'b0;
            cnt <= mem_req ? cnt + 4'h1 : 4'h0;
            mem_rdata <= ~mem_rdata;
        end
    end
    always @(posedge clk) begin
        if (notify && driver_ready) begin
            @(posedge clk);
            w = rw(AV);
            while (seen != w[31:16]) begin
                f = rw(AV + 64'h4 + 64'({seen[1], 2'b00}));
                hd = seen[0] ? f[31:16] : f[15:0];
                f = rw(DT + 64'({hd, 4'hC}));
                ln = rw(DT + 64'({hd, 4'h8}));
                // Indirect descriptors never count as writable
                mem[US + 64'h4 + 64'({uidx[1:0], 3'b000})] = {16'h0, hd};
                mem[US + 64'h8 + 64'({uidx[1:0], 3'b000})] = (f[1] && !f[2]) ? ln : 32'h0;
                uidx = uidx + 16'h1;
                mem[US] = {uidx, 16'h0};
                seen = seen + 16'h1;
            end
            dev_irq = 1'b1;
            repeat (4) @(posedge clk);
            dev_irq = 1'b0;
        end
    end
endmodule : srq_dev_model

//--- tb/test_srq_driver.sv
// Self-checking bench for the queue controller.
`timescale 1ns/1ps
module test_srq_driver
    import srq_pkg::*;
;
    typedef struct packed {logic [31:0] ln; logic [31:0] p; logic [31:0] el;} srq_row_s;
    srq_row_s rows [6] = '{'{16, 2, 0}, '{64, 3, 64}, '{1, 3, 1}, '{32'hFFFFFFFF, 3, 32'hFFFFFFFF},
        '{0, 3, 0}, '{8, 2, 0}};
    logic clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic mem_req, mem_we, mem_ack, driver_ready, notify, dev_irq;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, mem_rdata, mem_wdata, d, a;
    logic [63:0] mem_addr;
    logic [3:0] mem_be, dly = 4'h0;
    int failures = 0, n_checks = 0, cyc = 0;
    srq_driver dut (.clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .mem_req,
        .mem_we, .mem_addr, .mem_wdata, .mem_be, .mem_ack, .mem_rdata, .driver_ready, .notify, .dev_irq);
    srq_dev_model m (.clk, .reset_n, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_be, .mem_ack,
        .mem_rdata, .notify, .driver_ready, .dly, .dev_irq);
    task automatic results;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : results
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] ad, input logic [31:0] v);
        @(posedge clk);
        reg_addr <= ad;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] ad, output logic [31:0] v);
        @(posedge clk);
        reg_addr <= ad;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask : rd
    task automatic push(input logic [31:0] ln, input logic [31:0] p);
        logic [31:0] s;
        wr(REG_BUF_LO, 32'h1000 + ln);
        wr(REG_BUF_HI, 32'h0);
        wr(REG_BUF_LEN, ln);
        wr(REG_PUSH, p);
        for (int i = 0; i < 50; i++) begin
            rd(REG_STATUS, s);
            if (s[0] === 1'b0) break;
        end
    endtask : push
    task automatic reap(input logic [15:0] n);
        d = 32'h0;
        for (int i = 0; i < 300 && d[15:0] !== n; i++) rd(REG_DONE, d);
    endtask : reap
    initial forever #20 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        // Generous ceiling: the whole sequence needs a few hundred cycles
        if (cyc == 20000) begin
            failures++;
            results();
        end
    end
    initial begin
        #50 chk("rdata in reset", 32'h0, reg_rdata);
        chk("ready in reset", 32'h0, {31'h0, driver_ready});
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        rd(REG_STATUS, d);
        chk("cfg ok qsize 0", 32'h0, {31'h0, d[1]});
        push(4, 2);
        rd(REG_STATUS, d);
        chk("push refused", 32'h1, {31'h0, d[6:2] != 5'h0});
        wr(REG_CTRL, 32'h8);
        wr(REG_QSIZE, 32'h3);
        wr(REG_DESC_LO, 32'h108);
        wr(REG_AVAIL_LO, 32'h200);
        wr(REG_USED_LO, 32'h300);
        rd(REG_STATUS, d);
        chk("cfg ok bad", 32'h0, {31'h0, d[1]});
        wr(REG_QSIZE, 32'h4);
        wr(REG_DESC_LO, 32'h100);
        wr(REG_IND_LO, 32'h400);
        wr(REG_CTRL, 32'h3);
        rd(REG_STATUS, d);
        chk("cfg ok good", 32'h1, {31'h0, d[1]});
        chk("ready set", 32'h1, {31'h0, driver_ready});
        rd(8'hFC, d);
        chk("unmapped read", 32'h0, d);
        for (int i = 0; i < 6; i++) begin
            dly = 4'(3 * (i % 2));
            push(rows[i].ln, rows[i].p);
            reap(16'(i + 1));
            chk("head id", i % 4, {16'h0, d[31:16]});
            rd(REG_DONE_LEN, d);
            chk("used len", rows[i].el, d);
            chk("desc len", rows[i].ln, m.rw(64'h108 + 64'(16 * (i % 4))));
            chk("desc flags", {30'h0, rows[i].p[0], 1'b0}, m.rw(64'h10C + 64'(16 * (i % 4))));
            a = m.rw(64'h200);
            chk("avail idx", i + 1, {16'h0, a[31:16]});
        end
        push(16, 5);
        push(8, 3);
        reap(16'h7);
        rd(REG_DONE_LEN, d);
        chk("indirect len", 32'h0, d);
        chk("ind main len", 32'h20, m.rw(64'h128));
        chk("ind main flags", {16'h0, DESC_F_INDIRECT}, m.rw(64'h12C));
        chk("ind entry0", {16'h1, DESC_F_NEXT | DESC_F_WRITE}, m.rw(64'h40C));
        push(4, 1);
        push(4, 2);
        rd(REG_STATUS, d);
        chk("order error", 32'h1, {31'h0, d[2]});
        wr(REG_CTRL, 32'h8);
        wr(REG_CTRL, 32'h1);
        rd(REG_CTRL, d);
        chk("ctrl rd", 32'h1, d);
        push(4, 6);
        rd(REG_STATUS, d);
        chk("ind refused", 32'h1, {31'h0, d[5]});
        results();
    end
endmodule : test_srq_driver
